// >>> shared/dht_params.svh
// offsets, field positions, reset values and counts of the two-half timer
// assumes an apb slave with 32-bit data, one aligned word per register
`ifndef DHT_PARAMS_SVH
`define DHT_PARAMS_SVH

// register byte offsets
`define DHT_OFF_CFG      12'h000
`define DHT_OFF_AMODE    12'h004
`define DHT_OFF_BMODE    12'h008
`define DHT_OFF_CTL      12'h00C
`define DHT_OFF_MASK     12'h018
`define DHT_OFF_RAW      12'h01C
`define DHT_OFF_MSKD     12'h020
`define DHT_OFF_CLR      12'h024
`define DHT_OFF_ALOAD    12'h028
`define DHT_OFF_BLOAD    12'h02C
`define DHT_OFF_AMATCH   12'h030
`define DHT_OFF_BMATCH   12'h034
`define DHT_OFF_APRE     12'h038
`define DHT_OFF_BPRE     12'h03C
`define DHT_OFF_ACNT     12'h048
`define DHT_OFF_BCNT     12'h04C

// global mode codes
`define DHT_CFG_32       3'h0
`define DHT_CFG_RTC      3'h1
`define DHT_CFG_16       3'h4

// half mode field codes and capture-mode bit
`define DHT_MR_ONESHOT   2'h1
`define DHT_MR_PERIODIC  2'h2
`define DHT_MR_CAPTURE   2'h3
`define DHT_MR_CMR_BIT   2

// control bits, half b sits one stride above half a
`define DHT_CTL_STRIDE   8
`define DHT_CTL_EN       0
`define DHT_CTL_FREEZE   1
`define DHT_CTL_EVT      2
`define DHT_CTL_CLOCK_COUNT_ENABLE    4
`define DHT_CTL_TRIG     5

// event field codes
`define DHT_EVT_RISE     2'h0
`define DHT_EVT_FALL     2'h1
`define DHT_EVT_BOTH     2'h3

// flag bits, half b one stride above half a
`define DHT_FLG_TO       0
`define DHT_FLG_EM       1
`define DHT_FLG_RTC      3

// reset values
`define DHT_RST_CNT      16'hFFFF
`define DHT_RST_LOAD     16'hFFFF
`define DHT_RST_PRE      8'h00
`define DHT_RTC_FIRST    32'h0000_0001

// slow clock edges per one-second tick (32.768 kHz down to 1 Hz)
`define DHT_RTC_HZ_IN    32768
`define DHT_RTC_HZ_OUT   1
`define DHT_RTC_DIV      15'((`DHT_RTC_HZ_IN / `DHT_RTC_HZ_OUT) - 1)

`endif

// >>> shared/dht_pkg.sv
// types of the two-half timer
// constants live in dht_params.svh
package dht_pkg;

    // global mode decoded from the configuration register
    typedef enum logic [2:0]
    {
        DHT_GM_32  = 3'b001,
        DHT_GM_RTC = 3'b010,
        DHT_GM_16  = 3'b100
    } dht_gmode_t;

endpackage

// >>> rtl/dht_timer.sv
// two 16-bit halves joined as a 32-bit timer or real-time clock, or split
// into 16-bit timers and edge counters; apb register slave
// assumes capture pins and the debug-halt line are asynchronous to clk
//
// Summary of operation
// - reset: block idle, controls cleared, counters and loads 0xFFFF, prescales zero
// - config 0 is 32-bit timer, 1 is real-time clock, 4 splits halves
// - 32-bit modes: write to half a load fills both load halves
// - 32-bit modes: half a count read returns half b over half a
// - 32-bit timer counts down; only half a mode field picks one-shot/periodic
// - at zero reload next cycle; one-shot stops and clears half a enable
// - 32-bit zero sets sticky timeout flag, masked flag, optional converter trigger
// - freeze bit holds a half's timer or clock count while the debugger halts; edge counting ignores it
// - clock count enable keeps counting through a debug halt
// - real-time clock counts up, first entry loads one
// - slow clock on half a pin is divided to one tick per second
// - clock match rolls count to zero, sets flags; clear bit removes them
// - split halves are 16-bit down-counters with 8-bit prescaler
// - half at zero reloads load and prescale; one-shot clears its enable
// - half timeout sets sticky flags and optional converter trigger
// - prescale p stretches each count step to p+1 clocks
// - edge count mode counts down on rising, falling or both edges
// - each chosen edge decrements; equal to match sets match flags
// - after match reload, clear enable, ignore further edges
// - writing one to a clear bit removes raw and masked flags
`timescale 1ns/1ps
`include "dht_params.svh"

module dht_timer
(
    input  wire logic        clk,          // system clock, 40 MHz
    input  wire logic        rst_n,        // synchronous reset, active low
    input  wire logic        psel,         // apb select
    input  wire logic        penable,      // apb enable
    input  wire logic        pwrite,       // apb direction, high writes
    input  wire logic [11:0] paddr,        // apb byte address
    input  wire logic [31:0] pwdata,       // apb write data
    output logic      [31:0] prdata,       // apb read data
    output logic             pready,       // apb ready
    output logic             pslverr,      // apb error on unmapped address
    input  wire logic        ccp_a_in,     // capture pin of half a, also slow clock
    input  wire logic        ccp_b_in,     // capture pin of half b
    input  wire logic        debug_halt,   // processor halted by debugger
    output logic             conv_trigger, // one-cycle converter trigger pulse
    output logic             timer_irq     // any masked flag set
);

    // register state, packed so [1:0][15:0] reads as half b over half a
    logic [1:0][15:0] cnt_reg, cnt_next;
    logic [1:0][15:0] load_reg, load_next;
    logic [1:0][15:0] match_reg, match_next;
    logic [1:0][7:0]  pre_reg, pre_next;
    logic [1:0][7:0]  ps_reg, ps_next;
    logic [1:0][2:0]  mode_reg, mode_next;
    logic [2:0]       cfg_reg, cfg_next;
    logic [15:0]      ctl_reg, ctl_next;
    logic [15:0]      mask_reg, mask_next;
    logic [15:0]      raw_reg, raw_next;
    logic [14:0]      div_reg, div_next;
    logic [1:0]       sync1_reg, sync2_reg, sync3_reg;
    logic             halt1_reg, halt2_reg;
    logic             trig_next, irq_next;
    logic [31:0]      rd_data;
    logic [15:0]      hw_set, hw_clr;
    logic [1:0]       ev_to, ev_em;
    logic             ev_rtc, ev_tick;
    dht_pkg::dht_gmode_t gmode;

    // apb decode: one wait state, the word is taken on the second access cycle
    wire       acc_first = psel & penable & ~pready;
    wire       acc_done  = psel & penable & pready;
    wire       wr_fire   = acc_done & pwrite;
    wire       hit_cfg   = paddr == `DHT_OFF_CFG;
    wire       hit_amode = paddr == `DHT_OFF_AMODE;
    wire       hit_bmode = paddr == `DHT_OFF_BMODE;
    wire       hit_ctl   = paddr == `DHT_OFF_CTL;
    wire       hit_mask  = paddr == `DHT_OFF_MASK;
    wire       hit_raw   = paddr == `DHT_OFF_RAW;
    wire       hit_mskd  = paddr == `DHT_OFF_MSKD;
    wire       hit_clr   = paddr == `DHT_OFF_CLR;
    wire       hit_aload = paddr == `DHT_OFF_ALOAD;
    wire       hit_bload = paddr == `DHT_OFF_BLOAD;
    wire       hit_amat  = paddr == `DHT_OFF_AMATCH;
    wire       hit_bmat  = paddr == `DHT_OFF_BMATCH;
    wire       hit_apre  = paddr == `DHT_OFF_APRE;
    wire       hit_bpre  = paddr == `DHT_OFF_BPRE;
    wire       hit_acnt  = paddr == `DHT_OFF_ACNT;
    wire       hit_bcnt  = paddr == `DHT_OFF_BCNT;
    wire       mapped    = hit_cfg | hit_amode | hit_bmode | hit_ctl | hit_mask | hit_raw | hit_mskd
                         | hit_clr | hit_aload | hit_bload | hit_amat | hit_bmat | hit_apre | hit_bpre
                         | hit_acnt | hit_bcnt;
    wire [15:0] clr_bits = (wr_fire & hit_clr) ? pwdata[15:0] : 16'h0000;
    wire [15:0] mskd     = raw_reg & mask_reg;

    // global mode; an unused configuration code behaves as split halves
    always_comb
    begin
        unique case (cfg_reg)
            `DHT_CFG_32:  gmode = dht_pkg::DHT_GM_32;
            `DHT_CFG_RTC: gmode = dht_pkg::DHT_GM_RTC;
            default:      gmode = dht_pkg::DHT_GM_16;
        endcase
    end

    wire is32  = gmode == dht_pkg::DHT_GM_32;
    wire isrtc = gmode == dht_pkg::DHT_GM_RTC;
    wire is16  = gmode == dht_pkg::DHT_GM_16;
    wire wide  = is32 | isrtc;

    // per-half control fields
    wire [1:0] en     = {ctl_reg[`DHT_CTL_STRIDE + `DHT_CTL_EN], ctl_reg[`DHT_CTL_EN]};
    wire [1:0] freeze = {ctl_reg[`DHT_CTL_STRIDE + `DHT_CTL_FREEZE], ctl_reg[`DHT_CTL_FREEZE]};
    wire [1:0] te     = {ctl_reg[`DHT_CTL_STRIDE + `DHT_CTL_TRIG], ctl_reg[`DHT_CTL_TRIG]};
    wire       clock_count_enable  = ctl_reg[`DHT_CTL_CLOCK_COUNT_ENABLE];
    // clock count enable overrides the debug freeze of both halves
    wire [1:0] stall  = freeze & {2{halt2_reg & ~clock_count_enable}};

    // edges from the second and third stages so the first synchroniser flop stays private
    wire [1:0] rise = sync2_reg & ~sync3_reg;
    wire [1:0] fall = ~sync2_reg & sync3_reg;

    // load write paths; in wide modes half a's address takes the whole word
    wire [1:0] wr_load = {wr_fire & (hit_bload | (hit_aload & wide)), wr_fire & hit_aload};
    wire [1:0] wr_mat  = {wr_fire & (hit_bmat | (hit_amat & wide)), wr_fire & hit_amat};
    wire [31:0] load_wd = (wide & (hit_aload | hit_amat)) ? pwdata : {pwdata[15:0], pwdata[15:0]};

    // counting engine for all modes
    always_comb
    begin
        logic [1:0] md;
        logic       sel_edge;
        md = 2'h0;
        sel_edge = 1'b0;
        cnt_next = cnt_reg;
        ps_next = ps_reg;
        div_next = div_reg;
        hw_set = 16'h0000;
        hw_clr = 16'h0000;
        ev_to = 2'b00;
        ev_em = 2'b00;
        ev_rtc = 1'b0;
        ev_tick = 1'b0;
        trig_next = 1'b0;
        // 32-bit one-shot/periodic: only half a's mode field matters
        if (is32 && en[0] && !stall[0]
            && (mode_reg[0][1:0] == `DHT_MR_ONESHOT || mode_reg[0][1:0] == `DHT_MR_PERIODIC))
        begin
            if (cnt_reg == 32'h0000_0000)
            begin
                cnt_next = load_reg;
                ev_to[0] = 1'b1;
                trig_next = te[0];
                if (mode_reg[0][1:0] == `DHT_MR_ONESHOT)
                    hw_clr[`DHT_CTL_EN] = 1'b1;
            end
            else
                cnt_next = cnt_reg - 32'h0000_0001;
        end
        // real-time clock: divide the slow pin clock, count up, roll at match
        if (isrtc && en[0] && !stall[0])
        begin
            if (rise[0])
            begin
                if (div_reg == `DHT_RTC_DIV)
                begin
                    div_next = 15'h0000;
                    ev_tick = 1'b1;
                end
                else
                    div_next = div_reg + 15'h0001;
            end
            if (ev_tick)
            begin
                if (cnt_reg == match_reg)
                begin
                    cnt_next = 32'h0000_0000;
                    ev_rtc = 1'b1;
                end
                else
                    cnt_next = cnt_reg + 32'h0000_0001;
            end
        end
        // split halves: timer with prescaler, or edge counter
        for (int i = 0; i < 2; i++)
        begin
            md = mode_reg[i][1:0];
            if (is16 && en[i] && !stall[i]
                && (md == `DHT_MR_ONESHOT || md == `DHT_MR_PERIODIC))
            begin
                if (ps_reg[i] != 8'h00)
                    ps_next[i] = ps_reg[i] - 8'h01;
                else if (cnt_reg[i] == 16'h0000)
                begin
                    cnt_next[i] = load_reg[i];
                    ps_next[i] = pre_reg[i];
                    ev_to[i] = 1'b1;
                    trig_next = trig_next | te[i];
                    if (md == `DHT_MR_ONESHOT)
                        hw_clr[i * `DHT_CTL_STRIDE + `DHT_CTL_EN] = 1'b1;
                end
                else
                begin
                    cnt_next[i] = cnt_reg[i] - 16'h0001;
                    ps_next[i] = pre_reg[i];
                end
            end
            unique case (ctl_reg[i * `DHT_CTL_STRIDE + `DHT_CTL_EVT +: 2])
                `DHT_EVT_RISE: sel_edge = rise[i];
                `DHT_EVT_FALL: sel_edge = fall[i];
                `DHT_EVT_BOTH: sel_edge = rise[i] | fall[i];
                default:       sel_edge = rise[i];
            endcase
            if (is16 && en[i] && md == `DHT_MR_CAPTURE && !mode_reg[i][`DHT_MR_CMR_BIT] && sel_edge)
            begin
                if (cnt_reg[i] - 16'h0001 == match_reg[i])
                begin
                    cnt_next[i] = load_reg[i];
                    ev_em[i] = 1'b1;
                    hw_clr[i * `DHT_CTL_STRIDE + `DHT_CTL_EN] = 1'b1;
                end
                else
                    cnt_next[i] = cnt_reg[i] - 16'h0001;
            end
        end
        // a load write presets the count so enabling starts from it; an armed edge counter keeps its count
        if (wr_load[0] && wide)
            cnt_next = load_wd;
        for (int i = 0; i < 2; i++)
        begin
            if (wr_load[i] && is16 && !(en[i] && mode_reg[i][1:0] == `DHT_MR_CAPTURE))
                cnt_next[i] = load_wd[i * 16 +: 16];
        end
        // first entry into the real-time clock presets the count
        if (wr_fire && hit_cfg && pwdata[2:0] == `DHT_CFG_RTC && !isrtc)
        begin
            cnt_next = `DHT_RTC_FIRST;
            div_next = 15'h0000;
        end
        for (int i = 0; i < 2; i++)
        begin
            hw_set[i * `DHT_CTL_STRIDE + `DHT_FLG_TO] = ev_to[i];
            hw_set[i * `DHT_CTL_STRIDE + `DHT_FLG_EM] = ev_em[i];
        end
        hw_set[`DHT_FLG_RTC] = ev_rtc;
    end

    // software register next values; set wins over clear on the flags
    assign cfg_next   = (wr_fire & hit_cfg) ? pwdata[2:0] : cfg_reg;
    assign mode_next  = {(wr_fire & hit_bmode) ? pwdata[2:0] : mode_reg[1],
                         (wr_fire & hit_amode) ? pwdata[2:0] : mode_reg[0]};
    assign ctl_next   = (wr_fire & hit_ctl) ? pwdata[15:0] : (ctl_reg & ~hw_clr);
    assign mask_next  = (wr_fire & hit_mask) ? pwdata[15:0] : mask_reg;
    assign raw_next   = (raw_reg & ~clr_bits) | hw_set;
    assign load_next  = {wr_load[1] ? load_wd[31:16] : load_reg[1],
                         wr_load[0] ? load_wd[15:0] : load_reg[0]};
    assign match_next = {wr_mat[1] ? load_wd[31:16] : match_reg[1],
                         wr_mat[0] ? load_wd[15:0] : match_reg[0]};
    assign pre_next   = {(wr_fire & hit_bpre) ? pwdata[7:0] : pre_reg[1],
                         (wr_fire & hit_apre) ? pwdata[7:0] : pre_reg[0]};
    assign irq_next   = |(raw_next & mask_reg);

    // read mux; wide modes show the joined halves on half a's addresses
    always_comb
    begin
        rd_data = 32'h0000_0000;
        if (hit_cfg)   rd_data = {29'h0, cfg_reg};
        if (hit_amode) rd_data = {29'h0, mode_reg[0]};
        if (hit_bmode) rd_data = {29'h0, mode_reg[1]};
        if (hit_ctl)   rd_data = {16'h0, ctl_reg};
        if (hit_mask)  rd_data = {16'h0, mask_reg};
        if (hit_raw)   rd_data = {16'h0, raw_reg};
        if (hit_mskd)  rd_data = {16'h0, mskd};
        if (hit_aload) rd_data = wide ? load_reg : {16'h0, load_reg[0]};
        if (hit_bload) rd_data = {16'h0, load_reg[1]};
        if (hit_amat)  rd_data = wide ? match_reg : {16'h0, match_reg[0]};
        if (hit_bmat)  rd_data = {16'h0, match_reg[1]};
        if (hit_apre)  rd_data = {24'h0, pre_reg[0]};
        if (hit_bpre)  rd_data = {24'h0, pre_reg[1]};
        if (hit_acnt)  rd_data = wide ? cnt_reg : {16'h0, cnt_reg[0]};
        if (hit_bcnt)  rd_data = {16'h0, cnt_reg[1]};
    end

    // apb answer: ready, data and error all registered
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= acc_first;
            prdata <= acc_first ? rd_data : 32'h0000_0000;
            pslverr <= acc_first & ~mapped;
        end
    end

    // synchronisers for the asynchronous pins
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sync1_reg <= 2'b00;
            sync2_reg <= 2'b00;
            sync3_reg <= 2'b00;
            halt1_reg <= 1'b0;
            halt2_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= {ccp_b_in, ccp_a_in};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            halt1_reg <= debug_halt;
            halt2_reg <= halt1_reg;
        end
    end

    // control and configuration registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cfg_reg <= `DHT_CFG_32;
            mode_reg <= 6'h00;
            ctl_reg <= 16'h0000;
            mask_reg <= 16'h0000;
            raw_reg <= 16'h0000;
        end
        else
        begin
            cfg_reg <= cfg_next;
            mode_reg <= mode_next;
            ctl_reg <= ctl_next;
            mask_reg <= mask_next;
            raw_reg <= raw_next;
        end
    end

    // counters, loads, prescalers and outputs
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_reg <= {`DHT_RST_CNT, `DHT_RST_CNT};
            load_reg <= {`DHT_RST_LOAD, `DHT_RST_LOAD};
            match_reg <= 32'h0000_0000;
            pre_reg <= {`DHT_RST_PRE, `DHT_RST_PRE};
            ps_reg <= {`DHT_RST_PRE, `DHT_RST_PRE};
            div_reg <= 15'h0000;
            conv_trigger <= 1'b0;
            timer_irq <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            load_reg <= load_next;
            match_reg <= match_next;
            pre_reg <= pre_next;
            ps_reg <= ps_next;
            div_reg <= div_next;
            conv_trigger <= trig_next;
            timer_irq <= irq_next;
        end
    end

    // checks
    AST_RESET_LOADS: assert property (@(posedge clk) !rst_n |=> cnt_reg == 32'hFFFF_FFFF
        && load_reg == 32'hFFFF_FFFF && pre_reg == 16'h0000 && ctl_reg == 16'h0000)
        else $error("reset values wrong");
    AST_WIDE_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
        wr_fire && hit_aload && wide |=> load_reg == $past(pwdata))
        else $error("wide load not split across halves");
    AST_WIDE_READ: assert property (@(posedge clk) disable iff (!rst_n)
        acc_first && hit_acnt && wide |=> prdata == $past(cnt_reg) && pready)
        else $error("wide count read not joined");
    AST_ONESHOT_END: assert property (@(posedge clk) disable iff (!rst_n)
        is32 && ev_to[0] && mode_reg[0][1:0] == `DHT_MR_ONESHOT && !(wr_fire && (hit_ctl || hit_aload))
        |=> !en[0] && cnt_reg == $past(load_reg)
        ##1 ($past(wr_load[0] || (wr_fire && hit_cfg)) || cnt_reg == $past(cnt_reg)))
        else $error("one-shot did not reload and stop");
    AST_TIMEOUT_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
        ev_to[0] |=> raw_reg[`DHT_FLG_TO] && conv_trigger == $past(te[0] | (ev_to[1] & te[1]))
        ##1 timer_irq == |(raw_reg & $past(mask_reg)))
        else $error("timeout flag or trigger missing");
    AST_FREEZE: assert property (@(posedge clk) disable iff (!rst_n)
        is16 && stall[1] && mode_reg[1][1:0] != `DHT_MR_CAPTURE && !wr_load[1] && !(wr_fire && hit_cfg)
        |=> cnt_reg[1] == $past(cnt_reg[1]))
        else $error("frozen half moved");
    AST_PRESCALE_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        is16 && en[0] && ps_reg[0] != 8'h00 && mode_reg[0][1:0] == `DHT_MR_PERIODIC && !wr_load[0] && !stall[0]
        && !(wr_fire && hit_cfg) |=> cnt_reg[0] == $past(cnt_reg[0]) && ps_reg[0] == $past(ps_reg[0]) - 8'h01)
        else $error("prescaler did not stretch the step");
    AST_RTC_ROLL: assert property (@(posedge clk) disable iff (!rst_n)
        ev_rtc && !wr_load[0] |=> cnt_reg == 32'h0000_0000 && raw_reg[`DHT_FLG_RTC])
        else $error("clock match did not roll over");
    AST_EDGE_MATCH: assert property (@(posedge clk) disable iff (!rst_n)
        ev_em[1] && !(wr_fire && hit_ctl) |=> !en[1] && raw_reg[`DHT_CTL_STRIDE + `DHT_FLG_EM]
        && cnt_reg[1] == $past(load_reg[1]))
        else $error("edge match did not stop the half");
    AST_IDLE_HALF: assert property (@(posedge clk) disable iff (!rst_n)
        is16 && !en[0] && !wr_load[0] && !(wr_fire && hit_cfg) |=> cnt_reg[0] == $past(cnt_reg[0]))
        else $error("disabled half changed its count");
    AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        clr_bits[`DHT_FLG_TO] && !ev_to[0] |=> !raw_reg[`DHT_FLG_TO] && !mskd[`DHT_FLG_TO])
        else $error("clear bit did not remove the flag");

endmodule

// >>> test/dht_pin_model.sv
// capture pin driver standing in for the board side of the timer
// assumes go is a one-cycle request from the bench, sampled on clk rising edges
`timescale 1ns/1ps

module dht_pin_model
(
    input  wire logic       clk,    // system clock
    input  wire logic       go,     // start a burst of edges
    input  wire logic [7:0] n_edge, // number of edges in the burst
    output logic            pin     // capture pin level
);
    logic [7:0] left_reg = 8'h00;
    logic [1:0] div_reg = 2'h0;
    logic       lvl_reg = 1'b0;

    // the pin idles low, the level the edge detector resets to
    assign pin = lvl_reg;

    // each level stands four clocks, twice the minimum the edge detector needs
    always @(posedge clk)
    begin
        if (go)
        begin
            left_reg <= n_edge;
            div_reg  <= 2'h0;
        end
        else if (left_reg != 8'h00)
        begin
            div_reg <= div_reg + 2'h1;
            if (div_reg == 2'h3)
            begin
                lvl_reg  <= ~lvl_reg;
                left_reg <= left_reg - 8'h01;
            end
        end
    end
endmodule

// >>> test/dht_timer_tb_top.sv
// self-checking bench of the two-half timer: reset table, 32-bit one-shot,
// prescaled 16-bit periodic and edge count; assumes the apb slave of dht_timer
`timescale 1ns/1ps
`include "dht_params.svh"

module dht_timer_tb_top;
    typedef struct packed {logic [11:0] a; logic [31:0] d; logic e;} dht_row_t;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, conv_trigger, timer_irq, ccp_b, go = 1'b0;
    logic        halt = 1'b0;
    logic [31:0] q;
    logic        e;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          c;
    dht_row_t    rows [8] = '{'{`DHT_OFF_CFG, 32'h0000_0000, 1'b0}, '{`DHT_OFF_CTL, 32'h0000_0000, 1'b0},
        '{`DHT_OFF_ALOAD, 32'hFFFF_FFFF, 1'b0}, '{`DHT_OFF_ACNT, 32'hFFFF_FFFF, 1'b0},
        '{`DHT_OFF_APRE, 32'h0000_0000, 1'b0}, '{`DHT_OFF_BPRE, 32'h0000_0000, 1'b0},
        '{`DHT_OFF_RAW, 32'h0000_0000, 1'b0}, '{12'h100, 32'h0000_0000, 1'b1}};

    always #12.5 clk = ~clk;

    dht_timer uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ccp_a_in(1'b0), .ccp_b_in(ccp_b),
        .debug_halt(halt), .conv_trigger(conv_trigger), .timer_irq(timer_irq));
    dht_pin_model pins (.clk(clk), .go(go), .n_edge(8'h06), .pin(ccp_b));

    // one apb transfer: setup, access, hold until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1)
            n_mismatch++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk($sformatf("reg %h", a), exp, q);
    endtask

    // bounded wait for the next converter trigger pulse, c counts the clocks
    task automatic wait_trig();
        c = 0;
        do begin @(posedge clk); c++; end while (conv_trigger !== 1'b1 && c < 5000);
    endtask

    task automatic print_verdict();
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            apb(1'b0, rows[i].a, 32'h0000_0000);
            chk($sformatf("row %0d data", i), rows[i].d, q);
            chk($sformatf("row %0d error", i), {31'h0, rows[i].e}, {31'h0, e});
        end
        // 32-bit one-shot with a short load; the joined write is seen in half b first
        apb(1'b1, `DHT_OFF_ALOAD, 32'h1234_5678);
        rd(`DHT_OFF_BLOAD, 32'h0000_1234);
        apb(1'b1, `DHT_OFF_AMODE, 32'h0000_0001);
        apb(1'b1, `DHT_OFF_BMODE, 32'h0000_0002);   // half b mode must be ignored
        apb(1'b1, `DHT_OFF_ALOAD, 32'h0000_0040);
        apb(1'b1, `DHT_OFF_MASK, 32'h0000_0001);
        apb(1'b1, `DHT_OFF_CTL, 32'h0000_0021);
        wait_trig();
        chk("one-shot trigger seen", 32'h0000_0001, {31'h0, conv_trigger});
        rd(`DHT_OFF_CTL, 32'h0000_0020);
        rd(`DHT_OFF_ACNT, 32'h0000_0040);
        rd(`DHT_OFF_RAW, 32'h0000_0001);
        rd(`DHT_OFF_MSKD, 32'h0000_0001);
        chk("irq", 32'h0000_0001, {31'h0, timer_irq});
        apb(1'b1, `DHT_OFF_CLR, 32'h0000_0001);
        rd(`DHT_OFF_RAW, 32'h0000_0000);
        rd(`DHT_OFF_MSKD, 32'h0000_0000);
        // 16-bit periodic: ten steps of four clocks between triggers
        apb(1'b1, `DHT_OFF_CFG, 32'h0000_0004);
        apb(1'b1, `DHT_OFF_AMODE, 32'h0000_0002);
        apb(1'b1, `DHT_OFF_APRE, 32'h0000_0003);
        apb(1'b1, `DHT_OFF_ALOAD, 32'h0000_0009);
        apb(1'b1, `DHT_OFF_CTL, 32'h0000_0021);
        wait_trig();
        wait_trig();
        chk("periodic spacing", 32'd40, c);
        // half b frozen by a debug halt, then kept running by the clock count enable
        apb(1'b1, `DHT_OFF_BLOAD, 32'h0000_1000);
        halt <= 1'b1;
        apb(1'b1, `DHT_OFF_CTL, 32'h0000_0300);
        rd(`DHT_OFF_BCNT, 32'h0000_1000);
        apb(1'b1, `DHT_OFF_CTL, 32'h0000_0310);
        rd(`DHT_OFF_BCNT, 32'h0000_0FFE);
        halt <= 1'b0;
        // edge count on half b: load 10, match 6, six edges of which two are ignored
        apb(1'b1, `DHT_OFF_CTL, 32'h0000_0000);
        apb(1'b1, `DHT_OFF_CLR, 32'h0000_030B);
        apb(1'b1, `DHT_OFF_BMODE, 32'h0000_0003);
        apb(1'b1, `DHT_OFF_BLOAD, 32'h0000_000A);
        apb(1'b1, `DHT_OFF_BMATCH, 32'h0000_0006);
        apb(1'b1, `DHT_OFF_CTL, 32'h0000_0D00);
        @(posedge clk) go <= 1'b1;
        @(posedge clk) go <= 1'b0;
        repeat (40) @(posedge clk);
        rd(`DHT_OFF_RAW, 32'h0000_0200);
        rd(`DHT_OFF_CTL, 32'h0000_0C00);
        rd(`DHT_OFF_BCNT, 32'h0000_000A);
        // a second reset in mid-run, then the first entry into the clock mode
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(`DHT_OFF_BCNT, 32'h0000_FFFF);
        rd(`DHT_OFF_CTL, 32'h0000_0000);
        apb(1'b1, `DHT_OFF_CFG, 32'h0000_0001);
        rd(`DHT_OFF_ACNT, 32'h0000_0001);
        print_verdict();
    end
endmodule
